// File: hw/dscg_defs.vh
// Register map, field positions and reset values of the deep-sleep clock gate block
`ifndef DSCG_DEFS_VH
`define DSCG_DEFS_VH

// Byte offsets within the system control window
`define DSCG_OFF_RUN 12'h0100
`define DSCG_OFF_SLEEP 12'h0110
`define DSCG_OFF_DEEP 12'h0128
`define DSCG_OFF_CFG 12'h0060
`define DSCG_OFF_IRQ_STAT 12'h01F0
`define DSCG_OFF_IRQ_MASK 12'h01F4
`define DSCG_OFF_FAULT_ADDR 12'h01F8

// Writable gating bits: 30 phy, 28 mac, 6..0 ports G..A
`define DSCG_GATE_MASK 32'h5000_007F
`define DSCG_GATE_RESET 32'h0000_0000
`define DSCG_BIT_PHY 5'h1E
`define DSCG_BIT_MAC 5'h1C
`define DSCG_BIT_PORT_A 5'h00
`define DSCG_BIT_PORT_G 5'h06

// Run configuration register: auto gating select
`define DSCG_BIT_AUTO_GATE 27
`define DSCG_CFG_MASK 32'h0800_0000
`define DSCG_CFG_RESET 32'h0000_0000

// Power modes
`define DSCG_MODE_RUN 2'h0
`define DSCG_MODE_SLEEP 2'h1
`define DSCG_MODE_DEEP 2'h2

// Interrupt status bits
`define DSCG_IRQ_FAULT 0
`define DSCG_IRQ_MODE 1
`define DSCG_IRQ_MASK_BITS 32'h0000_0003

// Units and their peripheral address decode (address bits 19:12)
`define DSCG_UNITS 9
`define DSCG_UNIT_SEL_LSB 12

`endif

// File: hw/dscg_mode_sync.v
// Three-stage synchroniser for the power mode pins
`timescale 1ns/10ps
`include "dscg_defs.vh"
module dscg_mode_sync (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Asynchronous mode pins
  input wire [1:0] mode_async,
  // Settled mode
  output reg [1:0] mode_q
);
  reg [1:0] s1_q;
  reg [1:0] s2_q;
  reg [1:0] s3_q;

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      mode_q <= `DSCG_MODE_RUN;
    end else begin
      s1_q <= mode_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Accept a change once two later stages agree
      if (s2_q == s3_q)
        mode_q <= s3_q;
    end
  end
endmodule // dscg_mode_sync

// File: hw/dscg_top.v
// Clock gate control for phy, mac and ports A..G across run, sleep and deep-sleep
//
// Behaviour
// - Set bit clocks unit; clear bit disables it
// - Access to gated unit answers bus fault
// - Reset clears all gating bits to zero
// - Separate run, sleep, deep-sleep sets; deep applies in deep-sleep only with auto gating
// - Sleep sets govern only with auto gating
// - Bit 30 enables phy unit clock
// - Bit 28 enables mac unit clock
// - Bits 0..6 enable ports A..G
// - Other bits read only, read zero
// - Deep-sleep register decoded at offset 0x128
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`include "dscg_defs.vh"
module dscg_top (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // APB register slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Power mode pins from the power controller
  input wire [1:0] power_mode,
  // Peripheral bus monitor
  input wire periph_req,
  input wire [31:0] periph_addr,
  output reg periph_fault,
  // Unit clock enables
  output reg phy_unit_clk_en,
  output reg mac_unit_clk_en,
  output reg port_a_clk_en,
  output reg port_b_clk_en,
  output reg port_c_clk_en,
  output reg port_d_clk_en,
  output reg port_e_clk_en,
  output reg port_f_clk_en,
  output reg port_g_clk_en,
  // Interrupt
  output reg irq
);
  // Software visible registers
  reg [31:0] run_clock_gate_2_q;
  reg [31:0] sleep_clock_gate_2_q;
  reg [31:0] deep_sleep_clock_gate_2_q;
  reg [31:0] run_clock_config_reg_q;
  reg [31:0] irq_stat_q;
  reg [31:0] irq_mask_q;
  reg [31:0] fault_addr_q;

  // Settled power mode and its last value
  wire [1:0] mode_q;
  reg [1:0] mode_prev_q;
  wire mode_changed;

  // Gate set selection and fault decode
  reg [31:0] active_d;
  reg [31:0] en_now_d;
  reg [3:0] unit_d;
  reg unit_gated_d;

  // Register decode and interrupt next state
  reg [31:0] rdata_d;
  reg addr_ok_d;
  reg [31:0] set_d;
  reg [31:0] stat_d;

  // Bus phases and configuration
  wire auto_clock_gating_select;
  wire apb_setup;
  wire apb_wr;

  // Mode settles four cycles after a pin change
  dscg_mode_sync u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .mode_async(power_mode),
    .mode_q(mode_q)
  );

  // Unit code for a peripheral address, zero selects no unit
  function [3:0] unit_of;
    input [7:0] sel;
    begin
      case (sel)
        8'h58: unit_of = 4'h1;
        8'h59: unit_of = 4'h2;
        8'h5A: unit_of = 4'h3;
        8'h5B: unit_of = 4'h4;
        8'h5C: unit_of = 4'h5;
        8'h5D: unit_of = 4'h6;
        8'h5E: unit_of = 4'h7;
        8'h48: unit_of = 4'h8;
        8'h49: unit_of = 4'h9;
        default: unit_of = 4'h0;
      endcase
    end
  endfunction

  // Map a unit code onto its gating bit position
  function [4:0] bit_of;
    input [3:0] u;
    begin
      case (u)
        4'h8: bit_of = `DSCG_BIT_MAC;
        4'h9: bit_of = `DSCG_BIT_PHY;
        default: bit_of = u - 5'd1;
      endcase
    end
  endfunction

  // Writable gating bits of a write word
  function [31:0] gate_bits;
    input [31:0] d;
    begin
      gate_bits = d & `DSCG_GATE_MASK;
    end
  endfunction

  // Unit select field of a peripheral address
  function [7:0] sel_of;
    input [31:0] a;
    begin
      sel_of = a[`DSCG_UNIT_SEL_LSB +: 8];
    end
  endfunction

  // Clear the status bits written as one
  function [31:0] w1c;
    input [31:0] cur;
    input [31:0] ones;
    begin
      w1c = cur & ~ones;
    end
  endfunction

  assign auto_clock_gating_select = run_clock_config_reg_q[`DSCG_BIT_AUTO_GATE];
  assign apb_setup = psel && !penable;
  // Writes land at the edge that closes the access phase
  assign apb_wr = psel && penable && pready && pwrite;
  assign mode_changed = (mode_q != mode_prev_q);

  // Pick the governing gate set
  always @* begin
    if (!auto_clock_gating_select)
      active_d = run_clock_gate_2_q;
    else if (mode_q == `DSCG_MODE_DEEP)
      active_d = deep_sleep_clock_gate_2_q;
    else if (mode_q == `DSCG_MODE_SLEEP)
      active_d = sleep_clock_gate_2_q;
    else
      active_d = run_clock_gate_2_q;
  end

  // Register read decode
  always @* begin
    rdata_d = 32'h0000_0000;
    addr_ok_d = 1'b1;
    case (paddr)
      `DSCG_OFF_RUN: rdata_d = run_clock_gate_2_q;
      `DSCG_OFF_SLEEP: rdata_d = sleep_clock_gate_2_q;
      `DSCG_OFF_DEEP: rdata_d = deep_sleep_clock_gate_2_q;
      `DSCG_OFF_CFG: rdata_d = run_clock_config_reg_q;
      `DSCG_OFF_IRQ_STAT: rdata_d = irq_stat_q;
      `DSCG_OFF_IRQ_MASK: rdata_d = irq_mask_q;
      `DSCG_OFF_FAULT_ADDR: rdata_d = fault_addr_q;
      default: addr_ok_d = 1'b0;
    endcase
  end

  // Enables as the units see them in this cycle
  always @* begin
    en_now_d = 32'h0000_0000;
    en_now_d[`DSCG_BIT_PHY] = phy_unit_clk_en;
    en_now_d[`DSCG_BIT_MAC] = mac_unit_clk_en;
    en_now_d[`DSCG_BIT_PORT_A] = port_a_clk_en;
    en_now_d[1] = port_b_clk_en;
    en_now_d[2] = port_c_clk_en;
    en_now_d[3] = port_d_clk_en;
    en_now_d[4] = port_e_clk_en;
    en_now_d[5] = port_f_clk_en;
    en_now_d[`DSCG_BIT_PORT_G] = port_g_clk_en;
  end

  // Fault judged on the registered enables, the clock the unit has now
  always @* begin
    unit_d = unit_of(sel_of(periph_addr));
    unit_gated_d = 1'b0;
    if (periph_req && unit_d != 4'h0)
      unit_gated_d = !en_now_d[bit_of(unit_d)];
  end

  // Interrupt events; set wins over write-one clear
  always @* begin
    set_d = 32'h0000_0000;
    set_d[`DSCG_IRQ_FAULT] = unit_gated_d;
    set_d[`DSCG_IRQ_MODE] = mode_changed;
    stat_d = irq_stat_q;
    if (apb_wr && paddr == `DSCG_OFF_IRQ_STAT)
      stat_d = w1c(irq_stat_q, pwdata);
    stat_d = (stat_d | set_d) & `DSCG_IRQ_MASK_BITS;
  end

  // APB slave: no wait states, answer in the access phase after setup
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok_d;
      prdata <= (apb_setup && !pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

  // Gate set writes, reserved bits stay zero
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      run_clock_gate_2_q <= `DSCG_GATE_RESET;
      sleep_clock_gate_2_q <= `DSCG_GATE_RESET;
      deep_sleep_clock_gate_2_q <= `DSCG_GATE_RESET;
    end else if (apb_wr) begin
      case (paddr)
        `DSCG_OFF_RUN: run_clock_gate_2_q <= gate_bits(pwdata);
        `DSCG_OFF_SLEEP: sleep_clock_gate_2_q <= gate_bits(pwdata);
        `DSCG_OFF_DEEP: deep_sleep_clock_gate_2_q <= gate_bits(pwdata);
        default: run_clock_gate_2_q <= run_clock_gate_2_q;
      endcase
    end
  end

  // Run configuration and interrupt mask writes
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      run_clock_config_reg_q <= `DSCG_CFG_RESET;
      irq_mask_q <= 32'h0000_0000;
    end else if (apb_wr) begin
      case (paddr)
        `DSCG_OFF_CFG: run_clock_config_reg_q <= pwdata & `DSCG_CFG_MASK;
        `DSCG_OFF_IRQ_MASK: irq_mask_q <= pwdata & `DSCG_IRQ_MASK_BITS;
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // Sticky status and mode history
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_stat_q <= 32'h0000_0000;
      mode_prev_q <= `DSCG_MODE_RUN;
    end else begin
      irq_stat_q <= stat_d;
      mode_prev_q <= mode_q;
    end
  end

  // Fault strobe and address of the last refused access
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      fault_addr_q <= 32'h0000_0000;
      periph_fault <= 1'b0;
    end else begin
      if (unit_gated_d)
        fault_addr_q <= periph_addr;
      periph_fault <= unit_gated_d;
    end
  end

  // Level interrupt while an unmasked status bit is set
  always @(posedge clk_sys) begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(stat_d & irq_mask_q);
  end

  // Registered so every enable comes straight from a flip-flop
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      phy_unit_clk_en <= 1'b0;
      mac_unit_clk_en <= 1'b0;
      port_a_clk_en <= 1'b0;
      port_b_clk_en <= 1'b0;
      port_c_clk_en <= 1'b0;
      port_d_clk_en <= 1'b0;
      port_e_clk_en <= 1'b0;
      port_f_clk_en <= 1'b0;
      port_g_clk_en <= 1'b0;
    end else begin
      phy_unit_clk_en <= active_d[`DSCG_BIT_PHY];
      mac_unit_clk_en <= active_d[`DSCG_BIT_MAC];
      port_a_clk_en <= active_d[`DSCG_BIT_PORT_A];
      port_b_clk_en <= active_d[1];
      port_c_clk_en <= active_d[2];
      port_d_clk_en <= active_d[3];
      port_e_clk_en <= active_d[4];
      port_f_clk_en <= active_d[5];
      port_g_clk_en <= active_d[`DSCG_BIT_PORT_G];
    end
  end
endmodule // dscg_top

// File: testbench/dscg_chk.sv
// Port assertions for the clock gate block
`timescale 1ns/10ps
module dscg_chk (
  // Clock and reset
  input logic clk_sys,
  input logic reset_n,
  // APB
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic [31:0] prdata,
  // Peripheral bus and enables
  input logic periph_req,
  input logic [31:0] periph_addr,
  input logic periph_fault,
  input logic port_a_clk_en,
  input logic phy_unit_clk_en,
  input logic mac_unit_clk_en,
  input logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire [7:0] u = periph_addr[19:12];
  a_apb_ready: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray data");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_port_fault: assert property (periph_req && u == 8'h58 && !port_a_clk_en |=> periph_fault)
    else $error("gated port no fault");
  a_port_clocked: assert property (periph_req && u == 8'h58 && port_a_clk_en |=> !periph_fault)
    else $error("clocked port fault");
  a_phy_fault: assert property (periph_req && u == 8'h49 && !phy_unit_clk_en |=> periph_fault)
    else $error("gated phy no fault");
  a_mac_fault: assert property (periph_req && u == 8'h48 && !mac_unit_clk_en |=> periph_fault)
    else $error("gated mac no fault");
  a_fault_cause: assert property (periph_fault |-> $past(periph_req)) else $error("stray fault");
  a_reset_clear: assert property (disable iff (1'b0) !reset_n |=> !irq && !port_a_clk_en
    && !phy_unit_clk_en && !mac_unit_clk_en) else $error("reset left enable");
  c_fault: cover property (periph_fault);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule // dscg_chk

// File: testbench/dscg_unit_model.sv
// Peripheral units issuing bus accesses
`timescale 1ns/10ps
module dscg_unit_model (
  // Clock
  input logic clk_sys,
  // Access request from the bench
  input logic go,
  input logic [7:0] sel,
  // Peripheral bus
  output logic periph_req = 1'b0,
  output logic [31:0] periph_addr = 32'h0000_0000
);
  // Idle address toggles so no stale value looks valid
  always @(posedge clk_sys) begin
    periph_req <= go;
    periph_addr <= go ? {12'h400, sel, 12'h000} : ~periph_addr;
  end
endmodule // dscg_unit_model

// File: testbench/tb_deep_sleep_clock_gate_control.sv
// Testbench for the deep-sleep clock gate block
`timescale 1ns/10ps
module tb_deep_sleep_clock_gate_control;
  logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [1:0] power_mode = 0;
  logic [7:0] sel = 0;
  wire [31:0] prdata, periph_addr;
  wire pready, pslverr, periph_req, periph_fault, irq;
  wire [8:0] en;
  wire [31:0] env = {23'h0, en};
  int mismatches = 0, cmp_count = 0, cyc = 0;
  dscg_top dut(.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .power_mode, .periph_req, .periph_addr, .periph_fault, .irq,
    .phy_unit_clk_en(en[8]), .mac_unit_clk_en(en[7]), .port_g_clk_en(en[6]),
    .port_f_clk_en(en[5]), .port_e_clk_en(en[4]), .port_d_clk_en(en[3]),
    .port_c_clk_en(en[2]), .port_b_clk_en(en[1]), .port_a_clk_en(en[0]));
  dscg_unit_model u_unit(.clk_sys, .go, .sel, .periph_req, .periph_addr);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 3000) begin
    mismatches++;
    final_report();
  end
  task final_report;
    $display("Compared %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task chk_en(input [31:0] e);
    repeat (2) @(posedge clk_sys);
    chk("enables", e, env);
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task acc(input [7:0] s, input f);
    sel <= s;
    go <= 1;
    @(posedge clk_sys) go <= 0;
    repeat (2) @(posedge clk_sys);
    chk("fault", {31'h0, f}, {31'h0, periph_fault});
    repeat (2) @(posedge clk_sys);
  endtask
  task t_reset;
    apb(12'h0128, 0, 0);
    chk("deep", 32'h0000_0000, rd);
    chk("err", 0, {31'h0, err});
    chk_en(32'h0000_0000);
  endtask
  task t_deep;
    apb(12'h0100, 1, 32'h0000_0001);
    apb(12'h0128, 1, 32'hFFFF_FFFF);
    apb(12'h0128, 0, 0);
    chk("deep", 32'h5000_007F, rd);
    apb(12'h0060, 1, 32'h0800_0000);
    power_mode <= 2'h2;
    repeat (4) @(posedge clk_sys);
    chk_en(32'h0000_01FF);
    apb(12'h0128, 1, 32'h0000_0041);
    chk_en(32'h0000_0041);
    acc(8'h58, 0);
    apb(12'h0128, 1, 32'h5000_0000);
    chk_en(32'h0000_0180);
    apb(12'h0110, 1, 32'h0000_0010);
    power_mode <= 2'h1;
    repeat (4) @(posedge clk_sys);
    chk_en(32'h0000_0010);
    acc(8'h58, 1);
    apb(12'h0060, 1, 0);
    chk_en(32'h0000_0001);
    apb(12'h01F0, 0, 0);
    chk("status", 32'h0000_0003, rd);
  endtask
  task t_fault;
    apb(12'h01F4, 1, 32'h0000_0001);
    apb(12'h01F0, 1, 32'h0000_0003);
    chk("irq", 0, {31'h0, irq});
    acc(8'h58, 0);
    acc(8'h59, 1);
    acc(8'h49, 1);
    acc(8'h48, 1);
    chk("irq", 1, {31'h0, irq});
    apb(12'h01F0, 0, 0);
    chk("status", 32'h0000_0001, rd);
    apb(12'h01F8, 0, 0);
    chk("fault_addr", 32'h4004_8000, rd);
    apb(12'h01F4, 1, 0);
    repeat (2) @(posedge clk_sys);
    chk("irq", 0, {31'h0, irq});
    apb(12'h01F0, 1, 32'h0000_0003);
    apb(12'h01F0, 0, 0);
    chk("status", 32'h0000_0000, rd);
  endtask
  task t_unmapped;
    apb(12'h0004, 1, 32'hFFFF_FFFF);
    chk("err", 1, {31'h0, err});
    apb(12'h0004, 0, 0);
    chk("err", 1, {31'h0, err});
    chk("unmapped", 32'h0000_0000, rd);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1;
    t_reset;
    t_deep;
    t_fault;
    t_unmapped;
    final_report;
  end
endmodule // tb_deep_sleep_clock_gate_control
bind dscg_top dscg_chk u_chk(.*);
